// ---- design/flash_poll_defs.svh ----
/*
 * Constants for the flash status poller: status bit positions, command
 * codes and bus timing counts. Assumes a 50 MHz controller clock.
 */
`ifndef FLASH_POLL_DEFS_SVH
`define FLASH_POLL_DEFS_SVH

`define POLL_BIT 3'd7
`define TOGGLE_BIT 3'd6
`define ERROR_BIT 3'd5
`define ETIMER_BIT 3'd3
`define ALT_TOGGLE_BIT 3'd2
`define ABORT_BIT 3'd1

`define CLK_PERIOD_NS 20
`define READ_ACCESS_NS 80
`define READ_ACCESS_CYC ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS 40
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_RECOVER_CYC 2

`define CMD_READ_RESET 8'hF0
`define CMD_UNLOCK1_ADDR 24'h000555
`define CMD_UNLOCK1_DATA 8'hAA
`define CMD_UNLOCK2_ADDR 24'h0002AA
`define CMD_UNLOCK2_DATA 8'h55

`endif

// ---- design/flash_poll_pkg.sv ----
/*
 * Types for the flash status poller. Assumes the defs header for values.
 */
package flash_poll_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_READ = 7'h02,
		ST_GAP = 7'h04,
		ST_EVAL = 7'h08,
		ST_WRITE = 7'h10,
		ST_WGAP = 7'h20,
		ST_DONE = 7'h40
	} state_t;

	typedef enum logic [2:0] {
		RES_OK = 3'h0,
		RES_ERROR = 3'h1,
		RES_ABORT = 3'h2,
		RES_SUSPENDED = 3'h3,
		RES_TIMER_OPEN = 3'h4
	} result_t;

	typedef struct packed {
		logic ce_b;
		logic oe_b;
		logic we_b;
	} bus_ctl_t;
endpackage

// ---- design/flash_status_poller.sv ----
/*
 * Host-side controller that polls a parallel NOR flash status byte until the
 * embedded program/erase finishes, then issues recovery commands on failure.
 * Assumes the flash pins are wired directly; data bus is split in/out/enable.
 */
// Function
// [RQ1] Program busy: poll bit reads inverted data
// [RQ2] Program done: poll bit equals written data
// [RQ3] Erase busy reads 0, done reads 1
// [RQ4] Suspend: poll bit 0 then 1
// [RQ5] Toggle bit flips each read while busy
// [RQ6] Suspend: toggle stops once suspended
// [RQ7] Error bit set on program/erase failure
// [RQ8] After error, send read/reset first
// [RQ9] Erase timer bit 0 allows appending blocks
// [RQ10] Alternative toggle flips inside erased blocks
// [RQ11] Buffer abort needs abort-and-reset command
// [RQ12] Status readable anytime on low byte
// [RQ13] Success returns device to array read
// [RQ14] Suspend: other blocks read array data
// [RQ15] Buffered poll value uses last loaded data
// [RQ16] Host ignores undefined status bits
// [RQ17] Poll at programmed location or erasing block
// [RQ18] Status fetched by ordinary bus read
// [RQ19] Ready/busy low while embedded operation runs
`timescale 1ns/1ps
`include "flash_poll_defs.svh"

module flash_status_poller #(
	parameter int ADDR_W = 24,
	parameter int ACC_CYC = `READ_ACCESS_CYC,
	parameter int WR_CYC = `WRITE_PULSE_CYC
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// User request
	input wire logic start_i,
	input wire logic is_erase_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] expect_i,
	// User result
	output logic done_o,
	output logic busy_o,
	output flash_poll_pkg::result_t result_o,
	output logic [7:0] status_o,
	// Flash pins
	output logic [ADDR_W-1:0] fl_addr_o,
	output flash_poll_pkg::bus_ctl_t fl_ctl_o,
	input wire logic [7:0] fl_dq_i,
	output logic [7:0] fl_dq_o,
	output logic fl_dq_oe_b_o,
	input wire logic fl_ready_busy_i
);
	initial begin
		if (ACC_CYC < 1 || WR_CYC < 1 || ADDR_W < 12 || ACC_CYC > 255 || WR_CYC > 255)
			$error("flash_status_poller: bad parameters");
	end

	flash_poll_pkg::state_t state;
	logic [7:0] cnt;
	logic [7:0] sample;
	logic [7:0] prev;
	logic have_prev;
	logic erase_op;
	logic [7:0] expect_val;
	logic [2:0] wr_left;
	logic [2:0] rb_sync;
	logic [3:0] pend;
	logic [3:0] cand;

	// True when the bit toggled between the last two reads
	function automatic logic toggled(input logic [7:0] a, input logic [7:0] b, input logic [2:0] pos);
		return a[pos] != b[pos];
	endfunction

	// Verdict of one read pair: bit 3 set means finish with the low result code
	function automatic logic [3:0] classify(input logic [7:0] p, input logic [7:0] s, input logic [7:0] e,
		input logic er, input logic rbb);
		if (!toggled(p, s, `TOGGLE_BIT)) begin
			if (er && !s[`POLL_BIT])
				return 4'h0; // [RQ3]
			if (er && toggled(p, s, `ALT_TOGGLE_BIT))
				return {1'b1, flash_poll_pkg::RES_SUSPENDED}; // [RQ4] [RQ6] [RQ10]
			if (!er && s[`POLL_BIT] != e[`POLL_BIT])
				return 4'h0; // [RQ1]
			return {1'b1, flash_poll_pkg::RES_OK}; // [RQ2] [RQ3] [RQ13] [RQ14]
		end
		if (s[`ERROR_BIT])
			return {1'b1, flash_poll_pkg::RES_ERROR}; // [RQ7]
		if (!er && s[`ABORT_BIT])
			return {1'b1, flash_poll_pkg::RES_ABORT}; // [RQ11]
		if (er && !s[`ETIMER_BIT] && !rbb)
			return {1'b1, flash_poll_pkg::RES_TIMER_OPEN}; // [RQ9]
		return 4'h0; // [RQ5]
	endfunction

	// Ready/busy pin synchronizer, stage 0 only feeds stage 1
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i)
			rb_sync <= 3'h7;
		else
			rb_sync <= {rb_sync[1:0], fl_ready_busy_i};
	end

	logic rb_busy;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i)
			rb_busy <= 1'b0;
		else if (rb_sync[2] == rb_sync[1])
			rb_busy <= !rb_sync[2]; // [RQ19]
	end

	// Verdict proposed by the latest two reads
	assign cand = classify(prev, sample, expect_val, erase_op, rb_busy);

	// Main sequencer
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			state <= flash_poll_pkg::ST_IDLE;
			cnt <= 8'h00;
			sample <= 8'h00;
			prev <= 8'h00;
			have_prev <= 1'b0;
			pend <= 4'h0;
			erase_op <= 1'b0;
			expect_val <= 8'h00;
			wr_left <= 3'h0;
			done_o <= 1'b0;
			busy_o <= 1'b0;
			result_o <= flash_poll_pkg::RES_OK;
			status_o <= 8'h00;
			fl_addr_o <= '0;
			fl_ctl_o <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1};
			fl_dq_o <= 8'h00;
			fl_dq_oe_b_o <= 1'b1;
		end else begin
			done_o <= 1'b0;
			case (state)
				flash_poll_pkg::ST_IDLE: begin
					if (start_i) begin
						// Poll address: programmed location or erasing block
						fl_addr_o <= addr_i; // [RQ17]
						erase_op <= is_erase_i;
						expect_val <= expect_i; // [RQ15]
						have_prev <= 1'b0;
						pend <= 4'h0;
						busy_o <= 1'b1;
						state <= flash_poll_pkg::ST_READ;
						cnt <= 8'(ACC_CYC);
						fl_ctl_o <= '{ce_b: 1'b0, oe_b: 1'b0, we_b: 1'b1}; // [RQ18]
					end
				end
				flash_poll_pkg::ST_READ: begin
					if (cnt == 8'h01) begin
						sample <= fl_dq_i; // [RQ12]
						fl_ctl_o <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1};
						cnt <= 8'(`BUS_RECOVER_CYC);
						state <= flash_poll_pkg::ST_GAP;
					end else
						cnt <= cnt - 8'h01;
				end
				flash_poll_pkg::ST_GAP: begin
					if (cnt == 8'h01)
						state <= flash_poll_pkg::ST_EVAL;
					else
						cnt <= cnt - 8'h01;
				end
				flash_poll_pkg::ST_EVAL: begin
					prev <= sample;
					have_prev <= 1'b1;
					status_o <= sample;
					state <= flash_poll_pkg::ST_READ;
					cnt <= 8'(ACC_CYC);
					fl_ctl_o <= '{ce_b: 1'b0, oe_b: 1'b0, we_b: 1'b1};
					// Only bits defined for the operation are judged
					if (have_prev) begin // [RQ16]
						// Act only when two read pairs in a row agree; the pair that
						// straddles the switch to array data is never trusted alone
						pend <= cand;
						if (cand[3] && cand == pend) begin
							fl_ctl_o <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1};
							result_o <= flash_poll_pkg::result_t'(cand[2:0]); // [RQ7] [RQ9] [RQ11]
							if (cand[2:0] inside {flash_poll_pkg::RES_ERROR, flash_poll_pkg::RES_ABORT}) begin
								wr_left <= (cand[2:0] == flash_poll_pkg::RES_ERROR) ? 3'h1 : 3'h3;
								state <= flash_poll_pkg::ST_WRITE;
								cnt <= 8'(WR_CYC);
							end else
								state <= flash_poll_pkg::ST_DONE;
						end
						// Otherwise keep polling while the bit toggles [RQ5]
					end
				end
				flash_poll_pkg::ST_WRITE: begin
					// Recovery: read/reset, or unlock pair then reset for abort
					fl_dq_oe_b_o <= 1'b0;
					fl_ctl_o <= '{ce_b: 1'b0, oe_b: 1'b1, we_b: 1'b0};
					case (wr_left)
						3'h3: begin
							fl_addr_o <= ADDR_W'(`CMD_UNLOCK1_ADDR);
							fl_dq_o <= `CMD_UNLOCK1_DATA;
						end
						3'h2: begin
							fl_addr_o <= ADDR_W'(`CMD_UNLOCK2_ADDR);
							fl_dq_o <= `CMD_UNLOCK2_DATA;
						end
						default: fl_dq_o <= `CMD_READ_RESET; // [RQ8] [RQ11]
					endcase
					if (cnt == 8'h01) begin
						fl_ctl_o <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1};
						cnt <= 8'(`BUS_RECOVER_CYC);
						state <= flash_poll_pkg::ST_WGAP;
					end else
						cnt <= cnt - 8'h01;
				end
				flash_poll_pkg::ST_WGAP: begin
					if (cnt == 8'h01) begin
						fl_dq_oe_b_o <= 1'b1;
						if (wr_left == 3'h1)
							state <= flash_poll_pkg::ST_DONE;
						else begin
							wr_left <= wr_left - 3'h1;
							cnt <= 8'(WR_CYC);
							state <= flash_poll_pkg::ST_WRITE;
						end
					end else
						cnt <= cnt - 8'h01;
				end
				flash_poll_pkg::ST_DONE: begin
					done_o <= 1'b1;
					busy_o <= 1'b0;
					state <= flash_poll_pkg::ST_IDLE;
				end
				default: state <= flash_poll_pkg::ST_IDLE;
			endcase
		end
	end

	sequence s_err_seen;
		state == flash_poll_pkg::ST_EVAL && have_prev && toggled(prev, sample, `TOGGLE_BIT) && sample[`ERROR_BIT];
	endsequence
	sequence s_abort_seen;
		state == flash_poll_pkg::ST_EVAL && have_prev && toggled(prev, sample, `TOGGLE_BIT)
		&& !sample[`ERROR_BIT] && !erase_op && sample[`ABORT_BIT];
	endsequence

	// Two failing polls one poll period apart must start the recovery writes
	AST_ERR_RESET: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RQ8]
		s_err_seen ##7 s_err_seen |=> state == flash_poll_pkg::ST_WRITE && wr_left == 3'h1)
		else $error("error not followed by read/reset");
	AST_ABORT_SEQ: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RQ11]
		s_abort_seen ##7 s_abort_seen |=> state == flash_poll_pkg::ST_WRITE && wr_left == 3'h3)
		else $error("abort not followed by abort-reset");
	AST_READ_CYCLE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RQ18]
		state == flash_poll_pkg::ST_READ |-> !fl_ctl_o.ce_b && !fl_ctl_o.oe_b && fl_ctl_o.we_b && fl_dq_oe_b_o)
		else $error("bad read cycle");
	AST_NO_CONTENTION: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RQ12]
		!fl_dq_oe_b_o |-> fl_ctl_o.oe_b)
		else $error("bus contention");
	AST_DONE_PULSE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RQ13]
		done_o |-> !busy_o ##1 !done_o)
		else $error("done not a pulse");
	AST_PROG_POLL: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RQ1]
		state == flash_poll_pkg::ST_EVAL && have_prev && !erase_op && !toggled(prev, sample, `TOGGLE_BIT)
		&& sample[`POLL_BIT] != expect_val[`POLL_BIT] |=> state == flash_poll_pkg::ST_READ)
		else $error("program finished early");
	AST_START: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RQ17]
		state == flash_poll_pkg::ST_IDLE && start_i |=> fl_addr_o == $past(addr_i) && busy_o)
		else $error("poll address wrong");
	AST_READ_LEN: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RQ5]
		$rose(state == flash_poll_pkg::ST_READ) |-> (state == flash_poll_pkg::ST_READ) [*4])
		else $error("read too short");
endmodule

// ---- tb/flash_dev_model.sv ----
/*
 * Behavioural flash device answering status reads for one embedded operation.
 * Assumes the bench pulses go_i to load the busy read count; mode and stored byte are used live.
 */
`timescale 1ns/1ps

module flash_dev_model (
	// Flash pins
	input flash_poll_pkg::bus_ctl_t ctl_i,
	input wire logic [7:0] dq_i,
	input wire logic dq_oe_b_i,
	output logic [7:0] dq_o,
	output logic ready_busy_o,
	// Bench control
	input wire logic go_i,
	input wire logic [2:0] mode_i,
	input wire logic [3:0] reads_i,
	input wire logic [7:0] val_i
);
	logic live = 1'b0;
	logic tg = 1'b0;
	logic at = 1'b0;
	logic busy;
	int left = 0;
	logic [7:0] last = 8'h00;
	logic [7:0] stat;

	always @(posedge go_i) begin
		live = 1'b1;
		left = reads_i;
		tg = 1'b0;
		at = 1'b0;
	end
	// End of a read: toggle bits advance
	always @(posedge ctl_i.oe_b) begin
		last = stat;
		if (live && (left > 0 || mode_i >= 3'h4))
			tg = ~tg;
		if (live && mode_i inside {3'h2, 3'h3, 3'h6})
			at = ~at;
		if (left > 0)
			left--;
	end
	// Read/reset or abort-reset closing command
	always @(negedge ctl_i.we_b) begin
		#1;
		if (!dq_oe_b_i && dq_i == 8'hF0)
			live = 1'b0;
	end
	assign busy = live && left > 0;
	always_comb begin
		stat = val_i;
		if (live) begin
			case (mode_i)
				3'h1: stat = busy ? {~val_i[7], tg, 6'h00} : val_i;
				3'h2: stat = busy ? {1'b0, tg, 3'b001, at, 2'b00} : 8'hFF;
				3'h3: stat = {~busy, tg, 2'b00, busy, at, 2'b00};
				3'h4: stat = {~val_i[7], tg, 1'b1, 5'h00};
				3'h5: stat = {~val_i[7], tg, 4'h0, 2'b10};
				3'h6: stat = {1'b0, tg, 3'b000, at, 2'b00};
				default: stat = val_i;
			endcase
		end
	end
	// Released bus shows the inverse of the last byte
	assign dq_o = (!ctl_i.ce_b && !ctl_i.oe_b) ? stat : ~last;
	assign ready_busy_o = !(busy && mode_i inside {3'h1, 3'h2, 3'h3, 3'h5});
endmodule

// ---- tb/tb_flash_status_poller.sv ----
/*
 * Self-checking bench for the status poller against the device model.
 * Assumes 50 MHz clock and synchronous active-low reset.
 */
`timescale 1ns/1ps

module tb_flash_status_poller;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic start = 1'b0;
	logic is_erase = 1'b0;
	logic [23:0] addr = 24'h000000;
	logic [7:0] expv = 8'h00;
	logic done, busy, dq_oe_b, rb, go = 1'b0;
	flash_poll_pkg::result_t res;
	flash_poll_pkg::bus_ctl_t ctl;
	logic [7:0] status, dq_out, dq_in;
	logic [23:0] fl_addr;
	logic [2:0] mode = 3'h1;
	logic [3:0] nrd = 4'h1;
	logic [31:0] rng = 32'd80043;
	logic [7:0] wq[$];
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;

	always #10 sys_clk = ~sys_clk;

	flash_status_poller i_flash_status_poller (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .start_i(start),
		.is_erase_i(is_erase), .addr_i(addr), .expect_i(expv), .done_o(done), .busy_o(busy),
		.result_o(res), .status_o(status), .fl_addr_o(fl_addr), .fl_ctl_o(ctl), .fl_dq_i(dq_in),
		.fl_dq_o(dq_out), .fl_dq_oe_b_o(dq_oe_b), .fl_ready_busy_i(rb));
	flash_dev_model i_flash_dev_model (.ctl_i(ctl), .dq_i(dq_out), .dq_oe_b_i(dq_oe_b), .dq_o(dq_in),
		.ready_busy_o(rb), .go_i(go), .mode_i(mode), .reads_i(nrd), .val_i(expv));

	function logic [31:0] nxt();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task chk(input string what, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, e, g);
		end
	endtask

	task close_out();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(negedge ctl.we_b) begin
		#1;
		wq.push_back(dq_out);
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			close_out();
		end
	end

	initial begin
		logic [2:0] eres;
		logic epoll;
		int k;
		repeat (10) @(negedge sys_clk);
		rst_b = 1'b1;
		for (int i = 0; i < 18; i++) begin
			@(negedge sys_clk);
			mode = 3'(1 + i % 6);
			expv = 8'(nxt());
			nrd = 4'(1 + nxt() % 6);
			addr = 24'(nxt());
			is_erase = mode inside {3'h2, 3'h3, 3'h6};
			go = 1'b1;
			start = 1'b1;
			wq.delete();
			@(negedge sys_clk);
			go = 1'b0;
			start = 1'b0;
			repeat (3) @(negedge sys_clk);
			chk("busy", 8'h01, {7'h00, busy});
			chk("ctl", 8'h01, {5'h00, ctl});
			for (int b = 0; b < 3; b++)
				chk("addr", addr[8*b +: 8], fl_addr[8*b +: 8]);
			start = 1'b1;
			@(negedge sys_clk);
			start = 1'b0;
			for (k = 0; k < 3000 && done !== 1'b1; k++)
				@(negedge sys_clk);
			eres = (mode == 3'h1 || mode == 3'h2) ? 3'h0 : (mode == 3'h6) ? 3'h4 :
				(mode == 3'h3) ? 3'h3 : (mode == 3'h4) ? 3'h1 : 3'h2;
			chk("done", 8'h01, {7'h00, done});
			chk("idle busy", 8'h00, {7'h00, busy});
			chk("result", {5'h00, eres}, {5'h00, res});
			epoll = mode == 3'h1 ? expv[7] : mode == 3'h6 ? 1'b0 : mode >= 3'h4 ? ~expv[7] : 1'b1;
			chk("poll", {7'h00, epoll}, {7'h00, status[7]});
			if (mode == 3'h1)
				chk("status", expv, status);
			if (mode == 3'h4)
				chk("err", 8'h01, {7'h00, status[5]});
			if (mode == 3'h5)
				chk("abort", 8'h01, {7'h00, status[1]});
			chk("writes", mode == 3'h4 ? 8'h01 : mode == 3'h5 ? 8'h03 : 8'h00, 8'(wq.size()));
			if (wq.size() > 0)
				chk("lastcmd", 8'hF0, wq[$]);
			repeat (40) begin
				@(negedge sys_clk);
				if (done === 1'b1)
					chk("extra done", 8'h00, 8'h01);
			end
			$display("test %0d mode %0d finished", i, mode);
		end
		close_out();
	end
endmodule
